// *** shared/gwc_pkg.sv ***
// Package for the port configuration block: subregister indices,
// field layout, reset values and widths.
// Assumes an 8-bit register access port with an address/control pair.
package gwc_pkg;
    localparam int PIN_W = 8;
    localparam int IRQ_N = 4;
    // Index written to the port address register
    localparam logic [7:0] IDX_STOP_WAKE = 8'h05;
    localparam logic [7:0] IDX_PULLUP = 8'h06;
    localparam logic [7:0] IDX_ALT_FN1 = 8'h07;
    localparam logic [7:0] IDX_ALT_FN1_ALIAS = 8'h08;
    localparam logic [7:0] IDX_IRQ_EDGE = 8'h08;
    localparam logic [7:0] IDX_IRQ_PAIR = 8'h09;
    // Reset values and the read value of reserved bits
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;
    localparam logic [3:0] RSVD_NIB = 4'h0;
    // Port selects on the register port
    localparam logic [1:0] PORT_A = 2'h0;
    localparam logic [1:0] PORT_B = 2'h1;
    localparam logic [1:0] PORT_C = 2'h2;
    localparam int NPORT = 3;
endpackage

// *** rtl/gwc_sync.sv ***
// Two-flop synchroniser bank for one port's pins; gwc_top uses one for each of Ports A, B and C.
// Assumes pins are asynchronous to i_clk in a real chip.
`timescale 1ns/1ps
module gwc_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = i_d;
        q_nxt = meta_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign o_q = q_r;
endmodule

// *** rtl/gwc_edge.sv ***
// One Port A interrupt line: pin-pair select, polarity, edge pulse.
// Assumes synchronised pin inputs.
`timescale 1ns/1ps
module gwc_edge (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_lo_pin,
    input wire logic i_hi_pin,
    input wire logic i_pair_sel,
    input wire logic i_rising,
    output logic o_irq
);
    logic prev_r;
    logic irq_r;
    logic prev_nxt;
    logic irq_nxt;
    logic sel;

    // Pick the pin, then compare against last cycle's level
    always_comb begin
        sel = i_pair_sel ? i_hi_pin : i_lo_pin;
        prev_nxt = sel;
        if (i_rising) begin
            irq_nxt = sel & ~prev_r;
        end else begin
            irq_nxt = ~sel & prev_r;
        end
    end

    // A switch of pair select can look like an edge; software should
    // reprogram with the line masked at the controller
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            prev_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign o_irq = irq_r;
endmodule

// *** rtl/gwc_top.sv ***
// Port configuration logic: stop-mode wake enables, weak pull-ups,
// second alternate-function bank and Port A interrupt edge logic.
// Assumes a CPU-side byte port: per-port address and control register
// writes and reads, one cycle each, and pins asynchronous to the bus.
//
// Summary of operation
// - Write subregister index to address register, then access it via control.
// - A selected alternate function drives the pin whatever the direction.
// - Index 05h selects the stop-mode wake-source enable subregister.
// - In stop mode an enabled pin wakes on any level change.
// - A pin with wake enable clear never starts recovery.
// - Index 06h selects the weak pull-up enable subregister.
// - Pull-up bit 1 turns the pin's weak pull-up on, 0 off.
// - Polarity bit 0 raises the interrupt on a falling edge.
// - Polarity bit 1 raises the interrupt on a rising edge.
// - Pair select 0 routes Port A pin n to interrupt line n.
// - Pair select 1 routes Port A pin n+4 to interrupt line n.
// - Alternate-function-1 bit 1 selects the second function of the pin.
// - Second bank sits in Port B; index 07h, with 08h accepted too.
`timescale 1ns/1ps
module gwc_top #(
    parameter int PIN_W = gwc_pkg::PIN_W
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_port_sel,
    input wire logic i_addr_wr,
    input wire logic i_ctl_wr,
    input wire logic i_ctl_rd,
    input wire logic [7:0] i_wdata,
    input wire logic i_stop_mode,
    input wire logic [PIN_W-1:0] i_port_a_pin,
    input wire logic [PIN_W-1:0] i_port_b_pin,
    input wire logic [PIN_W-1:0] i_port_c_pin,
    input wire logic [PIN_W-1:0] i_port_b_dir_in,
    input wire logic [PIN_W-1:0] i_port_b_af1_out,
    output logic [7:0] o_rdata,
    output logic [7:0] o_port_a_addr,
    output logic [7:0] o_port_b_addr,
    output logic [7:0] o_port_c_addr,
    output logic [PIN_W-1:0] o_stop_wake_enable_bit_a,
    output logic [PIN_W-1:0] o_stop_wake_enable_bit_b,
    output logic [PIN_W-1:0] o_stop_wake_enable_bit_c,
    output logic [PIN_W-1:0] o_weak_pullup_enable_bit_a,
    output logic [PIN_W-1:0] o_weak_pullup_enable_bit_b,
    output logic [PIN_W-1:0] o_weak_pullup_enable_bit_c,
    output logic [PIN_W-1:0] o_alt_function_bank1_bit,
    output logic [PIN_W-1:0] o_port_b_out_en,
    output logic [PIN_W-1:0] o_port_b_out,
    output logic o_stop_recovery,
    output logic [gwc_pkg::IRQ_N-1:0] o_port_a_irq
);
    localparam int NP = gwc_pkg::NPORT;
    localparam int NI = gwc_pkg::IRQ_N;

    logic [7:0] addr_r [NP];
    logic [7:0] addr_nxt [NP];
    logic [PIN_W-1:0] wake_r [NP];
    logic [PIN_W-1:0] wake_nxt [NP];
    logic [PIN_W-1:0] pull_r [NP];
    logic [PIN_W-1:0] pull_nxt [NP];
    logic [PIN_W-1:0] af1_r;
    logic [PIN_W-1:0] af1_nxt;
    logic [NI-1:0] edge_r;
    logic [NI-1:0] edge_nxt;
    logic [NI-1:0] pair_r;
    logic [NI-1:0] pair_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [PIN_W-1:0] boe_r;
    logic [PIN_W-1:0] boe_nxt;
    logic [PIN_W-1:0] bout_r;
    logic [PIN_W-1:0] bout_nxt;
    logic wake_evt_r;
    logic wake_evt_nxt;
    logic [PIN_W-1:0] pin_s [NP];
    logic [PIN_W-1:0] pin_prev_r [NP];
    logic [PIN_W-1:0] pin_prev_nxt [NP];
    logic [PIN_W-1:0] pin_raw [NP];
    logic [7:0] idx;
    int p;
    logic [NI-1:0] irq;

    assign pin_raw[0] = i_port_a_pin;
    assign pin_raw[1] = i_port_b_pin;
    assign pin_raw[2] = i_port_c_pin;

    // Synchronise every port before wake and edge detection
    generate
        for (genvar g = 0; g < NP; g++) begin : g_sync
            gwc_sync #(.W(PIN_W)) u_sync (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_d(pin_raw[g]),
                .o_q(pin_s[g])
            );
        end
    endgenerate

    // Interrupt lines; a pair for each of the four lines
    generate
        for (genvar n = 0; n < NI; n++) begin : g_irq
            gwc_edge u_edge (
                .i_clk(i_clk),
                .i_sys_rst(i_sys_rst),
                .i_lo_pin(pin_s[0][n]),
                .i_hi_pin(pin_s[0][n+NI]),
                .i_pair_sel(pair_r[n]),
                .i_rising(edge_r[n]),
                .o_irq(irq[n])
            );
        end
    endgenerate

    // Register port: address writes, control writes, control reads
    always_comb begin
        p = int'(i_port_sel);
        for (int k = 0; k < NP; k++) begin
            addr_nxt[k] = addr_r[k];
            wake_nxt[k] = wake_r[k];
            pull_nxt[k] = pull_r[k];
        end
        af1_nxt = af1_r;
        edge_nxt = edge_r;
        pair_nxt = pair_r;
        rdata_nxt = rdata_r;
        idx = 8'h00;
        if (p < NP) begin
            idx = addr_r[p];
            if (i_addr_wr) begin
                addr_nxt[p] = i_wdata;
            end else if (i_ctl_wr) begin
                if (idx == gwc_pkg::IDX_STOP_WAKE) begin
                    wake_nxt[p] = i_wdata[PIN_W-1:0];
                end else if (idx == gwc_pkg::IDX_PULLUP) begin
                    pull_nxt[p] = i_wdata[PIN_W-1:0];
                end else if (i_port_sel == gwc_pkg::PORT_B &&
                        (idx == gwc_pkg::IDX_ALT_FN1 ||
                        idx == gwc_pkg::IDX_ALT_FN1_ALIAS)) begin
                    af1_nxt = i_wdata[PIN_W-1:0];
                end else if (i_port_sel == gwc_pkg::PORT_A &&
                        idx == gwc_pkg::IDX_IRQ_EDGE) begin
                    edge_nxt = i_wdata[NI-1:0];
                end else if (i_port_sel == gwc_pkg::PORT_A &&
                        idx == gwc_pkg::IDX_IRQ_PAIR) begin
                    pair_nxt = i_wdata[NI-1:0];
                end
            end
            if (i_ctl_rd) begin
                rdata_nxt = 8'h00;
                if (idx == gwc_pkg::IDX_STOP_WAKE) begin
                    rdata_nxt = wake_r[p];
                end else if (idx == gwc_pkg::IDX_PULLUP) begin
                    rdata_nxt = pull_r[p];
                end else if (i_port_sel == gwc_pkg::PORT_B &&
                        (idx == gwc_pkg::IDX_ALT_FN1 ||
                        idx == gwc_pkg::IDX_ALT_FN1_ALIAS)) begin
                    rdata_nxt = af1_r;
                end else if (i_port_sel == gwc_pkg::PORT_A &&
                        idx == gwc_pkg::IDX_IRQ_EDGE) begin
                    rdata_nxt = {gwc_pkg::RSVD_NIB, edge_r};
                end else if (i_port_sel == gwc_pkg::PORT_A &&
                        idx == gwc_pkg::IDX_IRQ_PAIR) begin
                    rdata_nxt = {gwc_pkg::RSVD_NIB, pair_r};
                end
            end
        end
    end

    // Pin-side effects: wake detection and Port B pin ownership
    always_comb begin
        wake_evt_nxt = 1'b0;
        for (int k = 0; k < NP; k++) begin
            pin_prev_nxt[k] = pin_s[k];
            // Any change on an enabled pin; disabled pins never count
            if (i_stop_mode &&
                    |((pin_s[k] ^ pin_prev_r[k]) & wake_r[k])) begin
                wake_evt_nxt = 1'b1;
            end
        end
        // Alternate function overrides the direction setting
        for (int b = 0; b < PIN_W; b++) begin
            if (af1_r[b]) begin
                boe_nxt[b] = 1'b1;
                bout_nxt[b] = i_port_b_af1_out[b];
            end else begin
                boe_nxt[b] = ~i_port_b_dir_in[b];
                bout_nxt[b] = 1'b0;
            end
        end
    end

    // State registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            for (int k = 0; k < NP; k++) begin
                addr_r[k] <= gwc_pkg::RST_BYTE;
                wake_r[k] <= gwc_pkg::RST_BYTE;
                pull_r[k] <= gwc_pkg::RST_BYTE;
                pin_prev_r[k] <= gwc_pkg::RST_BYTE;
            end
            af1_r <= gwc_pkg::RST_BYTE;
            edge_r <= gwc_pkg::RST_NIB;
            pair_r <= gwc_pkg::RST_NIB;
            rdata_r <= gwc_pkg::RST_BYTE;
            boe_r <= gwc_pkg::RST_BYTE;
            bout_r <= gwc_pkg::RST_BYTE;
            wake_evt_r <= 1'b0;
        end else begin
            for (int k = 0; k < NP; k++) begin
                addr_r[k] <= addr_nxt[k];
                wake_r[k] <= wake_nxt[k];
                pull_r[k] <= pull_nxt[k];
                pin_prev_r[k] <= pin_prev_nxt[k];
            end
            af1_r <= af1_nxt;
            edge_r <= edge_nxt;
            pair_r <= pair_nxt;
            rdata_r <= rdata_nxt;
            boe_r <= boe_nxt;
            bout_r <= bout_nxt;
            wake_evt_r <= wake_evt_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_port_a_addr = addr_r[0];
    assign o_port_b_addr = addr_r[1];
    assign o_port_c_addr = addr_r[2];
    assign o_stop_wake_enable_bit_a = wake_r[0];
    assign o_stop_wake_enable_bit_b = wake_r[1];
    assign o_stop_wake_enable_bit_c = wake_r[2];
    assign o_weak_pullup_enable_bit_a = pull_r[0];
    assign o_weak_pullup_enable_bit_b = pull_r[1];
    assign o_weak_pullup_enable_bit_c = pull_r[2];
    assign o_alt_function_bank1_bit = af1_r;
    assign o_port_b_out_en = boe_r;
    assign o_port_b_out = bout_r;
    assign o_stop_recovery = wake_evt_r;
    assign o_port_a_irq = irq;
endmodule

// *** test/gwc_chk.sv ***
// Checker for the port configuration block, bound to gwc_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module gwc_chk #(
    parameter int PIN_W = 8
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [1:0] i_port_sel,
    input wire logic i_addr_wr,
    input wire logic i_ctl_wr,
    input wire logic [7:0] i_wdata,
    input wire logic i_stop_mode,
    input wire logic [PIN_W-1:0] i_port_b_dir_in,
    input wire logic [PIN_W-1:0] i_port_b_af1_out,
    input wire logic [7:0] o_port_a_addr,
    input wire logic [PIN_W-1:0] o_stop_wake_enable_bit_a,
    input wire logic [PIN_W-1:0] o_stop_wake_enable_bit_b,
    input wire logic [PIN_W-1:0] o_stop_wake_enable_bit_c,
    input wire logic [PIN_W-1:0] o_weak_pullup_enable_bit_a,
    input wire logic [PIN_W-1:0] o_alt_function_bank1_bit,
    input wire logic [PIN_W-1:0] o_port_b_out_en,
    input wire logic [PIN_W-1:0] o_port_b_out,
    input wire logic o_stop_recovery,
    input wire logic [gwc_pkg::IRQ_N-1:0] o_port_a_irq
);
    logic a_sel;
    logic pull_wr;
    logic no_wake;
    // Decoded Port A select, pull-up write strobe and the all-disabled wake condition
    assign a_sel = i_port_sel == gwc_pkg::PORT_A;
    assign pull_wr = i_ctl_wr && !i_addr_wr && a_sel &&
        o_port_a_addr == gwc_pkg::IDX_PULLUP;
    assign no_wake = (o_stop_wake_enable_bit_a | o_stop_wake_enable_bit_b |
        o_stop_wake_enable_bit_c) == '0;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_addr_load: assert property (i_addr_wr && a_sel |=>
        o_port_a_addr == $past(i_wdata)) else $error("address not loaded");
    a_addr_hold: assert property (!i_addr_wr |=>
        $stable(o_port_a_addr)) else $error("address changed unasked");
    a_pullup_write: assert property ($changed(o_weak_pullup_enable_bit_a) |->
        $past(pull_wr) && o_weak_pullup_enable_bit_a == $past(i_wdata))
        else $error("pull-up changed without write");
    a_portb_enable: assert property (!$past(i_sys_rst) &&
        $stable(o_alt_function_bank1_bit) |-> o_port_b_out_en ==
        (o_alt_function_bank1_bit | ~$past(i_port_b_dir_in)))
        else $error("port B enable wrong");
    a_portb_data: assert property (!$past(i_sys_rst) &&
        $stable(o_alt_function_bank1_bit) |-> o_port_b_out ==
        (o_alt_function_bank1_bit & $past(i_port_b_af1_out)))
        else $error("port B data wrong");
    a_irq_pulse: assert property (o_port_a_irq != '0 |=>
        (o_port_a_irq & $past(o_port_a_irq)) == '0)
        else $error("irq longer than a cycle");
    a_wake_in_stop: assert property (o_stop_recovery |->
        $past(i_stop_mode)) else $error("recovery outside stop");
    a_wake_disabled: assert property (no_wake [*5] |->
        !o_stop_recovery) else $error("recovery with no source");

    c_irq: cover property (o_port_a_irq != '0);
    c_wake: cover property (o_stop_recovery);
    c_af1: cover property ($changed(o_alt_function_bank1_bit));
endmodule

// *** test/gwc_pins.sv ***
// Far-side model of the Port A pins: outside drivers and weak pull-ups.
// Assumes the bench changes its drive just after a clock edge.
`timescale 1ns/1ps
module gwc_pins #(
    parameter int PIN_W = 8
) (
    input wire logic i_clk,
    input wire logic [PIN_W-1:0] i_pull_en,
    input wire logic [PIN_W-1:0] i_drv_en,
    input wire logic [PIN_W-1:0] i_drv_val,
    output logic [PIN_W-1:0] o_pin
);
    logic [PIN_W-1:0] float_r = '0;
    // A floating pin wanders, so no one may lean on a stale level
    always @(posedge i_clk) begin
        float_r <= ~float_r;
    end
    // Driven pins follow the driver, released ones rest on the pull-up if it is enabled, else wander
    always_comb begin
        o_pin = (i_drv_en & i_drv_val) | (~i_drv_en & i_pull_en);
        o_pin = o_pin | (~i_drv_en & ~i_pull_en & float_r);
    end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for gwc_top with a pin model on Port A.
// Assumes one 200 MHz clock and the CPU-side byte register port.
`timescale 1ns/1ps
module testbench;
    localparam int PIN_W = 8;
    localparam logic [1:0] PA = gwc_pkg::PORT_A;
    localparam logic [1:0] PB = gwc_pkg::PORT_B;
    localparam logic [1:0] PC = gwc_pkg::PORT_C;
    logic i_clk, i_sys_rst, i_addr_wr, i_ctl_wr, i_ctl_rd, i_stop_mode;
    logic o_stop_recovery;
    logic [1:0] i_port_sel;
    logic [3:0] o_port_a_irq, seen;
    logic [7:0] i_wdata, i_port_a_pin, i_port_b_pin, i_port_c_pin;
    logic [7:0] i_port_b_dir_in, i_port_b_af1_out, o_rdata, pa_drv, pa_en;
    logic [7:0] o_port_a_addr, o_port_b_addr, o_port_c_addr;
    logic [7:0] o_stop_wake_enable_bit_a, o_stop_wake_enable_bit_b;
    logic [7:0] o_stop_wake_enable_bit_c, o_weak_pullup_enable_bit_a;
    logic [7:0] o_weak_pullup_enable_bit_b, o_weak_pullup_enable_bit_c;
    logic [7:0] o_alt_function_bank1_bit, o_port_b_out_en, o_port_b_out;
    int bad_count = 0, checks_done = 0, ni, nr;

    gwc_top #(.PIN_W(PIN_W)) i_gwc_top (.*);
    gwc_pins #(.PIN_W(PIN_W)) i_gwc_pins (.i_clk, .i_drv_en(pa_en),
        .i_pull_en(o_weak_pullup_enable_bit_a), .i_drv_val(pa_drv),
        .o_pin(i_port_a_pin));

    // Free-running clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Index cycle, then one control write or read; ends settled
    task automatic acc(input logic [1:0] s, input logic [7:0] idx, v,
        input logic rd);
        @(posedge i_clk);
        i_port_sel <= s;
        i_addr_wr <= 1'b1;
        i_wdata <= idx;
        @(posedge i_clk);
        i_addr_wr <= 1'b0;
        i_ctl_wr <= !rd;
        i_ctl_rd <= rd;
        i_wdata <= v;
        @(posedge i_clk);
        i_ctl_wr <= 1'b0;
        i_ctl_rd <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [1:0] s, input logic [7:0] idx, e);
        acc(s, idx, 8'h00, 1'b1);
        chk("read data", e, o_rdata);
    endtask
    // Sample every cycle: a one-cycle pulse is counted exactly once
    task automatic flip(input int p);
        @(posedge i_clk);
        pa_drv[p] <= ~pa_drv[p];
        repeat (8) begin
            @(posedge i_clk);
            #1;
            ni += $countones(o_port_a_irq);
            seen |= o_port_a_irq;
            nr += int'(o_stop_recovery);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog: the tests need about 770 cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        int ln;
        int p;
        {i_addr_wr, i_ctl_wr, i_ctl_rd, i_stop_mode, i_port_sel} = '0;
        {i_wdata, i_port_b_pin, i_port_c_pin, pa_drv} = '0;
        i_port_b_dir_in = 8'hff;
        i_port_b_af1_out = 8'hc3;
        pa_en = 8'hff;
        i_sys_rst = 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdchk(PA, gwc_pkg::IDX_STOP_WAKE, 8'h00);
        rdchk(PA, gwc_pkg::IDX_PULLUP, 8'h00);
        rdchk(PB, gwc_pkg::IDX_ALT_FN1, 8'h00);
        rdchk(PA, gwc_pkg::IDX_IRQ_EDGE, 8'h00);
        rdchk(PA, gwc_pkg::IDX_IRQ_PAIR, 8'h00);
        $display("test reset values done");
        acc(PA, gwc_pkg::IDX_PULLUP, 8'ha5, 1'b0);
        chk("pull-up A", 8'ha5, o_weak_pullup_enable_bit_a);
        acc(2'h3, gwc_pkg::IDX_PULLUP, 8'hff, 1'b0);
        // The unmapped port touches no port's registers
        chk("pull-up B", 8'h00, o_weak_pullup_enable_bit_b);
        chk("pull-up C", 8'h00, o_weak_pullup_enable_bit_c);
        chk("wake B", 8'h00, o_stop_wake_enable_bit_b);
        rdchk(PA, gwc_pkg::IDX_PULLUP, 8'ha5);
        acc(PC, gwc_pkg::IDX_STOP_WAKE, 8'h3c, 1'b0);
        chk("wake C", 8'h3c, o_stop_wake_enable_bit_c);
        chk("address C", gwc_pkg::IDX_STOP_WAKE, o_port_c_addr);
        rdchk(PC, gwc_pkg::IDX_STOP_WAKE, 8'h3c);
        acc(PA, gwc_pkg::IDX_IRQ_EDGE, 8'hff, 1'b0);
        rdchk(PA, gwc_pkg::IDX_IRQ_EDGE, 8'h0f);
        acc(PA, gwc_pkg::IDX_IRQ_PAIR, 8'hf0, 1'b0);
        rdchk(PA, gwc_pkg::IDX_IRQ_PAIR, 8'h00);
        acc(PA, 8'h0a, 8'h77, 1'b0);
        rdchk(PA, 8'h0a, 8'h00);
        // Only pins whose alternate-function-1 bit is set get the second function here
        acc(PB, gwc_pkg::IDX_ALT_FN1_ALIAS, 8'h5a, 1'b0);
        chk("address B", gwc_pkg::IDX_ALT_FN1_ALIAS, o_port_b_addr);
        rdchk(PB, gwc_pkg::IDX_ALT_FN1, 8'h5a);
        i_port_b_dir_in <= 8'h0f;
        repeat (3) @(posedge i_clk);
        #1;
        chk("port B enable", 8'hfa, o_port_b_out_en);
        chk("port B data", 8'h42, o_port_b_out);
        $display("test register access done");
        for (int c = 0; c < 16; c++) begin
            ln = c % 4;
            p = ln + 4 * c[3];
            @(posedge i_clk);
            pa_drv <= c[2] ? 8'h00 : 8'hff;
            repeat (6) @(posedge i_clk);
            acc(PA, gwc_pkg::IDX_IRQ_EDGE, {7'h00, c[2]} << ln, 1'b0);
            acc(PA, gwc_pkg::IDX_IRQ_PAIR, {7'h00, c[3]} << ln, 1'b0);
            ni = 0;
            seen = 4'h0;
            flip(p);
            flip(p ^ 4);
            flip(p);
            chk("irq count", 8'h01, 8'(ni));
            chk("irq line", 8'h01 << ln, {4'h0, seen});
        end
        $display("test port A interrupts done");
        pa_drv <= 8'h00;
        acc(PA, gwc_pkg::IDX_STOP_WAKE, 8'h02, 1'b0);
        i_stop_mode <= 1'b1;
        repeat (6) @(posedge i_clk);
        nr = 0;
        flip(1);
        flip(2);
        flip(1);
        chk("wake count", 8'h02, 8'(nr));
        i_stop_mode <= 1'b0;
        repeat (3) @(posedge i_clk);
        flip(1);
        chk("wake outside stop", 8'h02, 8'(nr));
        $display("test stop wake done");
        acc(PA, gwc_pkg::IDX_PULLUP, 8'hff, 1'b0);
        pa_drv <= 8'hff;
        repeat (6) @(posedge i_clk);
        pa_en <= 8'h00;
        ni = 0;
        flip(0);
        chk("pulled pins quiet", 8'h00, 8'(ni));
        pa_en <= 8'hff;
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rdchk(PA, gwc_pkg::IDX_PULLUP, 8'h00);
        $display("test pull-up and reset done");
        complete_run();
    end
endmodule

bind gwc_top gwc_chk #(.PIN_W(PIN_W)) i_gwc_chk (.i_clk, .i_sys_rst,
    .i_port_sel, .i_addr_wr, .i_ctl_wr, .i_wdata, .i_stop_mode,
    .i_port_b_dir_in, .i_port_b_af1_out, .o_port_a_addr,
    .o_stop_wake_enable_bit_a, .o_stop_wake_enable_bit_b,
    .o_stop_wake_enable_bit_c, .o_weak_pullup_enable_bit_a,
    .o_alt_function_bank1_bit, .o_port_b_out_en, .o_port_b_out,
    .o_stop_recovery, .o_port_a_irq);
